// >>> inc/fpet_defs.svh
`ifndef FPET_DEFS_SVH
`define FPET_DEFS_SVH

`define FPET_BUS_PERIOD_NS   20
`define FPET_SW_BUS_CYC      5'h19
`define FPET_SW_OP_CYC       15'h0009
`define FPET_BW_BUS_CYC      5'h09
`define FPET_BW_OP_CYC       15'h0004
`define FPET_BURST_WORDS     64
`define FPET_ERASE_PULSES    16
`define FPET_SECTOR_OP_CYC   4000
`define FPET_MASS_OP_CYC     20000
`define FPET_CHECK_SETUP     5'h0A
`define FPET_CHECK_WORDS     65536
`define FPET_DIV_RESET       8'hF9

`endif

// >>> inc/fpet_pkg.sv
package fpet_pkg;

	typedef enum logic [1:0] {
		FPET_OP_PROGRAM = 2'h0,
		FPET_OP_SECTOR  = 2'h1,
		FPET_OP_MASS    = 2'h2,
		FPET_OP_CHECK   = 2'h3
	} fpet_op_t;

	typedef enum logic [3:0] {
		FPET_ST_IDLE  = 4'h1,
		FPET_ST_BUS   = 4'h2,
		FPET_ST_OP    = 4'h4,
		FPET_ST_CHECK = 4'h8
	} fpet_state_t;

	typedef struct packed {
		fpet_op_t    op;
		logic [15:0] addr;
	} fpet_cmd_t;

	typedef struct packed {
		logic       busy;
		logic       burst;
		logic       erase_pulse;
		logic [3:0] pulse_index;
	} fpet_stat_t;

endpackage

// >>> hdl/fpet_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none

module fpet_clkdiv
	import fpet_pkg::*;
#(
	parameter int DIV_W = 8
)
(
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_reset_n,
	// control
	input  wire logic [DIV_W-1:0] i_divider,
	input  wire logic             i_hold,
	// operating clock, one bus cycle wide per period
	output logic                  o_op_tick
);

	logic [DIV_W-1:0] count;

	// operating period is divider+1 bus cycles, phase restarted by hold
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			count <= '0;
		else if (i_hold || count == i_divider)
			count <= '0;
		else
			count <= count + 1'b1;
	end

	// combinational so a phase lasts whole periods; a registered tick
	// would stretch every operating phase by one bus cycle
	assign o_op_tick = !i_hold && count == i_divider;

endmodule // fpet_clkdiv

`default_nettype wire

// >>> hdl/fpet_core.sv
`include "fpet_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fpet_core
	import fpet_pkg::*;
#(
	parameter int DIV_W       = 8,
	parameter int CHECK_WORDS = `FPET_CHECK_WORDS,
	parameter int MASS_OP_CYC = `FPET_MASS_OP_CYC
)
(
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_reset_n,
	// configuration
	input  wire logic [DIV_W-1:0] i_flash_clock_divider,
	// command pipeline
	input  wire logic             i_cmd_valid,
	input  wire fpet_cmd_t        i_cmd,
	output logic                  o_cmd_ready,
	// array side
	output logic [15:0]           o_word_addr,
	output logic                  o_program_strobe,
	input  wire logic             i_word_blank,
	// completion and status
	output logic                  o_done,
	output logic                  o_check_fail,
	output fpet_stat_t            o_status
);

	localparam int PULSE_OP_CYC = `FPET_SECTOR_OP_CYC / `FPET_ERASE_PULSES;
	localparam logic [15:0] LAST_WORD = 16'(CHECK_WORDS - 1);

	fpet_state_t state;
	fpet_state_t next_state;
	fpet_op_t    cur_op;
	logic [4:0]  bus_cnt;
	logic [14:0] op_cnt;
	logic [3:0]  pulse_cnt;
	logic [5:0]  burst_cnt;
	logic [15:0] word_cnt;
	logic        op_tick;
	logic        accept;
	logic        op_last;
	logic        word_end;
	logic        burst_go;
	logic        check_end;

	//--------------------------------------------------------------------
	// operating clock
	//--------------------------------------------------------------------
	// held in phase zero outside the operating phase so every phase
	// lasts a whole number of operating periods
	fpet_clkdiv #(
		.DIV_W     (DIV_W)
	) u_clkdiv (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_divider (i_flash_clock_divider),
		.i_hold    (state != FPET_ST_OP),
		.o_op_tick (op_tick)
	);

	//--------------------------------------------------------------------
	// sequencing
	//--------------------------------------------------------------------
	// no bus frequency monitor exists; slow clocks simply stretch timing
	assign accept    = state == FPET_ST_IDLE && i_cmd_valid;
	assign op_last   = state == FPET_ST_OP && op_tick && op_cnt == 15'h0001;
	assign word_end  = op_last && cur_op == FPET_OP_PROGRAM;
	assign burst_go  = word_end && i_cmd_valid &&
		i_cmd.op == FPET_OP_PROGRAM &&
		burst_cnt != 6'(`FPET_BURST_WORDS - 1);
	assign check_end = state == FPET_ST_CHECK &&
		(!i_word_blank || word_cnt == LAST_WORD);
	assign o_cmd_ready = state == FPET_ST_IDLE || burst_go;

	always_comb
	begin
		next_state = state;
		unique case (state)
			FPET_ST_IDLE:
				if (accept)
					next_state = (i_cmd.op == FPET_OP_SECTOR ||
						i_cmd.op == FPET_OP_MASS) ? FPET_ST_OP : FPET_ST_BUS;
			FPET_ST_BUS:
				if (bus_cnt == 5'h01)
					next_state = cur_op == FPET_OP_CHECK ?
						FPET_ST_CHECK : FPET_ST_OP;
			FPET_ST_OP:
				if (burst_go)
					next_state = FPET_ST_BUS;
				else if (op_last && (cur_op != FPET_OP_SECTOR ||
					pulse_cnt == 4'hF))
					next_state = FPET_ST_IDLE;
			FPET_ST_CHECK:
				if (check_end)
					next_state = FPET_ST_IDLE;
			default:
				next_state = FPET_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state <= FPET_ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cur_op <= FPET_OP_PROGRAM;
		else if (accept)
			cur_op <= i_cmd.op;
	end

	//--------------------------------------------------------------------
	// bus cycle phase
	//--------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			bus_cnt <= 5'h00;
		else if (accept)
			bus_cnt <= i_cmd.op == FPET_OP_CHECK ?
				`FPET_CHECK_SETUP : `FPET_SW_BUS_CYC;
		else if (burst_go)
			bus_cnt <= `FPET_BW_BUS_CYC;
		else if (state == FPET_ST_BUS)
			bus_cnt <= bus_cnt - 5'h01;
	end

	//--------------------------------------------------------------------
	// operating clock phase
	//--------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			op_cnt <= 15'h0000;
		else if (accept)
			unique case (i_cmd.op)
				FPET_OP_SECTOR: op_cnt <= 15'(PULSE_OP_CYC);
				FPET_OP_MASS:   op_cnt <= 15'(MASS_OP_CYC);
				default:        op_cnt <= `FPET_SW_OP_CYC;
			endcase
		else if (burst_go)
			op_cnt <= `FPET_BW_OP_CYC;
		else if (op_last)
			op_cnt <= 15'(PULSE_OP_CYC);
		else if (state == FPET_ST_OP && op_tick)
			op_cnt <= op_cnt - 15'h0001;
	end

	// pulses follow each other with no gap
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			pulse_cnt <= 4'h0;
		else if (accept)
			pulse_cnt <= 4'h0;
		else if (op_last && cur_op == FPET_OP_SECTOR)
			pulse_cnt <= pulse_cnt + 4'h1;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			burst_cnt <= 6'h00;
		else if (accept || word_end)
			burst_cnt <= burst_go ? burst_cnt + 6'h01 : 6'h00;
	end

	//--------------------------------------------------------------------
	// array addressing and blank check
	//--------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			word_cnt <= 16'h0000;
		else if (accept)
			word_cnt <= i_cmd.op == FPET_OP_CHECK ? 16'h0000 : i_cmd.addr;
		else if (burst_go)
			word_cnt <= i_cmd.addr;
		else if (state == FPET_ST_CHECK && !check_end)
			word_cnt <= word_cnt + 16'h0001;
	end

	assign o_word_addr = word_cnt;

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_program_strobe <= 1'b0;
		else
			o_program_strobe <= next_state == FPET_ST_OP &&
				(accept ? i_cmd.op : cur_op) == FPET_OP_PROGRAM;
	end

	//--------------------------------------------------------------------
	// completion and status
	//--------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_done <= 1'b0;
		else
			o_done <= state != FPET_ST_IDLE && next_state == FPET_ST_IDLE;
	end

	// holds until the next blank check ends
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_check_fail <= 1'b0;
		else if (check_end)
			o_check_fail <= !i_word_blank;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_status <= '0;
		else
		begin
			o_status.busy        <= next_state != FPET_ST_IDLE;
			o_status.burst       <= burst_go || (burst_cnt != 6'h00 &&
				!word_end && state != FPET_ST_IDLE);
			o_status.erase_pulse <= next_state == FPET_ST_OP &&
				(accept ? i_cmd.op : cur_op) == FPET_OP_SECTOR;
			o_status.pulse_index <= pulse_cnt +
				4'((op_last && cur_op == FPET_OP_SECTOR) ? 1 : 0);
		end
	end

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	// bus cycles since the last operating tick, for the period check
	logic [DIV_W:0] tick_gap;

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			tick_gap <= '0;
		else if (state != FPET_ST_OP || op_tick)
			tick_gap <= {{DIV_W{1'b0}}, 1'b1};
		else
			tick_gap <= tick_gap + 1'b1;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_prog_start;
		accept && i_cmd.op == FPET_OP_PROGRAM;
	endsequence

	sequence s_check_start;
		accept && i_cmd.op == FPET_OP_CHECK;
	endsequence

	a_prog_bus_phase: assert property (s_prog_start |=>
		(state == FPET_ST_BUS)[*8] ##17 state == FPET_ST_BUS
		##1 state == FPET_ST_OP)
		else $error("single word bus phase not 25 cycles");

	a_burst_bus_phase: assert property (burst_go |=>
		(state == FPET_ST_BUS)[*8] ##1 state == FPET_ST_BUS
		##1 state == FPET_ST_OP)
		else $error("burst word bus phase not 9 cycles");

	a_burst_limit: assert property (word_end &&
		burst_cnt == 6'(`FPET_BURST_WORDS - 1) |=> state != FPET_ST_BUS)
		else $error("burst longer than one row");

	a_burst_ends: assert property (word_end && !i_cmd_valid |=>
		state == FPET_ST_IDLE ##1 !o_status.burst)
		else $error("burst kept without queued word");

	a_op_load: assert property (s_prog_start |=>
		op_cnt == `FPET_SW_OP_CYC)
		else $error("single word op count wrong");

	a_pulse_count: assert property (op_last && cur_op == FPET_OP_SECTOR &&
		pulse_cnt != 4'hF |=> state == FPET_ST_OP &&
		op_cnt == 15'(PULSE_OP_CYC))
		else $error("erase pulses not back to back");

	a_mass_load: assert property (accept && i_cmd.op == FPET_OP_MASS |=>
		state == FPET_ST_OP && op_cnt == 15'(MASS_OP_CYC))
		else $error("mass erase count wrong");

	a_check_min: assert property (s_check_start ##11 !i_word_blank |=>
		state == FPET_ST_IDLE && o_check_fail)
		else $error("blank check minimum not 11 cycles");

	a_check_seq: assert property (state == FPET_ST_CHECK && !check_end |=>
		word_cnt == $past(word_cnt) + 16'h0001)
		else $error("blank check skipped a word");

	a_divider: assert property (state == FPET_ST_OP && op_tick |->
		tick_gap == {1'b0, i_flash_clock_divider} + 1'b1)
		else $error("operating clock period wrong");

endmodule // fpet_core

`default_nettype wire

// >>> testbench/fpet_array_model.sv
`timescale 1ns/1ps
`default_nettype none

module fpet_array_model
(
	// address from the sequencer, first dirty address from the test
	input  wire logic [15:0] i_word_addr,
	input  wire logic [15:0] i_first_dirty,
	// blank answer
	output logic             o_word_blank
);
	// ------------------
	// blank map
	// ------------------
	// one dirty word only: the check must stop there anyway
	assign o_word_blank = (i_word_addr != i_first_dirty);
endmodule // fpet_array_model

`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
	import fpet_pkg::*;
;
	localparam int OPP = 2;
	localparam int SW  = 25 + 9 * OPP + 2;
	localparam int BW  = 9 + 4 * OPP;
	logic        ref_clk;
	logic        reset_n;
	logic        cmd_valid;
	fpet_cmd_t   cmd;
	logic        cmd_ready;
	logic [15:0] word_addr;
	logic        program_strobe;
	logic        word_blank;
	logic        done;
	logic        check_fail;
	fpet_stat_t  status;
	logic [15:0] first_dirty;
	int          fails;
	int          n_compared;
	int          strobes;
	int          pulses;
	int          top_index;
	int          bad_addr;
	int          busy_cyc;
	logic [8:0]  divider;

	fpet_core #(.DIV_W(9), .CHECK_WORDS(16), .MASS_OP_CYC(20)) fpet_core_i (
		.i_ref_clk(ref_clk), .i_reset_n(reset_n),
		.i_flash_clock_divider(divider),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
		.o_word_addr(word_addr), .o_program_strobe(program_strobe),
		.i_word_blank(word_blank), .o_done(done),
		.o_check_fail(check_fail), .o_status(status));

	fpet_array_model fpet_array_model_i (.i_word_addr(word_addr),
		.i_first_dirty(first_dirty), .o_word_blank(word_blank));

	// ------------------
	// helpers
	// ------------------
	task automatic check(input logic [31:0] got, exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %s got %0d exp %0d", $time, what,
				got, exp);
		end
	endtask

	// done latency is the designer's, so allow a few cycles of slack
	task automatic near(input int got, exp, input string what);
		check((got > exp - 4 && got < exp + 4) ? exp : got, exp, what);
	endtask

	task automatic end_of_test;
		$display("compared %0d, wrong %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic run(input fpet_op_t op, input logic [15:0] a, output int n);
		logic       last;
		logic [3:0] idx;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, addr: a};
		do
			@(negedge ref_clk);
		while (cmd_ready !== 1'b1);
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		n = 0;
		strobes = 0;
		pulses = 0;
		top_index = 0;
		busy_cyc = 0;
		last = 1'b0;
		idx = 4'h0;
		do
		begin
			@(negedge ref_clk);
			n++;
			if (program_strobe === 1'b1)
				strobes++;
			if (program_strobe === 1'b1 && word_addr !== a)
				bad_addr++;
			// pulses run back to back, so a new index marks a new pulse
			if (status.erase_pulse === 1'b1 && (last !== 1'b1 ||
				status.pulse_index !== idx))
				pulses++;
			if (status.busy === 1'b1)
				busy_cyc++;
			last = status.erase_pulse;
			idx = status.pulse_index;
			if (int'(status.pulse_index) > top_index)
				top_index = int'(status.pulse_index);
		end
		while (done !== 1'b1 && n < 20000);
	endtask

	// ------------------
	// scenarios
	// ------------------
	task automatic t_program;
		int n;
		run(FPET_OP_PROGRAM, 16'h0123, n);
		near(n, SW, "single word time");
		near(strobes, 9 * OPP, "operating phase");
		check(bad_addr, 0, "program address");
		check(busy_cyc, n - 1, "busy span");
		@(posedge ref_clk);
		divider <= 9'h0F9;
		run(FPET_OP_PROGRAM, 16'h0456, n);
		near(n, 25 + 9 * 250 + 2, "slow single word time");
		near(strobes, 9 * 250, "slow operating phase");
		check(bad_addr, 0, "slow program address");
		check(busy_cyc, n - 1, "slow busy span");
		@(posedge ref_clk);
		divider <= 9'(OPP - 1);
		$display("single program test done");
	endtask

	task automatic t_burst;
		int   acc;
		int   n;
		logic seen;
		logic take;
		acc = 0;
		n = 0;
		seen = 1'b0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: FPET_OP_PROGRAM, addr: 16'h0100};
		forever
		begin
			@(negedge ref_clk);
			if (done === 1'b1 || n > 5000)
				break;
			if (status.burst === 1'b1)
				seen = 1'b1;
			take = (cmd_ready === 1'b1);
			if (take)
				acc++;
			@(posedge ref_clk);
			n++;
			if (take)
				cmd.addr <= cmd.addr + 16'h0001;
		end
		// the 65th is taken from idle only after this loop has ended
		check(acc, 64, "words taken");
		check(seen, 1'b1, "burst flag");
		near(n, SW + 63 * BW + 1, "whole row time");
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		n = 1;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (done !== 1'b1 && n < 500);
		near(n, SW, "word after burst");
		$display("burst test done");
	endtask

	task automatic t_erase;
		int n;
		run(FPET_OP_SECTOR, 16'h0000, n);
		check(pulses, 16, "erase pulses");
		check(top_index, 15, "last pulse index");
		near(n, 4000 * OPP + 2, "sector time");
		run(FPET_OP_MASS, 16'h0000, n);
		near(n, 20 * OPP + 2, "mass time");
		$display("erase test done");
	endtask

	task automatic t_blank;
		int k[3] = '{0, 5, 16};
		int n[3];
		foreach (k[i])
		begin
			@(posedge ref_clk);
			first_dirty <= 16'(k[i]);
			run(FPET_OP_CHECK, 16'h0000, n[i]);
			check(check_fail, k[i] < 16, "blank result");
		end
		near(n[0], 11, "shortest check");
		check(n[1] - n[0], 5, "one cycle a word");
		check(n[2] - n[0], 15, "longest check");
		$display("blank check test done");
	endtask

	// ------------------
	// run
	// ------------------
	initial
	begin
		ref_clk = 1'b0;
		forever
			#10 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (40000) @(posedge ref_clk);
		fails++;
		$display("wrong value at %0t: watchdog ran out", $time);
		end_of_test();
	end

	initial
	begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		first_dirty = '0;
		divider = 9'(OPP - 1);
		fails = 0;
		n_compared = 0;
		bad_addr = 0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_program();
		t_burst();
		t_erase();
		t_blank();
		end_of_test();
	end
endmodule // tb

`default_nettype wire
